// ### hdl/cfi_pkg.sv
/*
  Shared constants, field layout and decode functions for the
  configuration-memory fault injection block and its error flag.
  Assumes the TAP controller and the detection engine live outside.
*/
package cfi_pkg;
  // Scan-side and internal injection word.
  localparam int FI_W = 21;
  localparam logic [FI_W-1:0] FI_RESET = 21'h000000;
  localparam int TYPE_HI = 20;
  localparam int TYPE_LO = 19;
  localparam int LOC_HI = 18;
  localparam int LOC_LO = 8;
  localparam int VAL_HI = 7;
  localparam int VAL_LO = 0;
  localparam int LOC_W = LOC_HI - LOC_LO + 1;
  localparam int VAL_W = VAL_HI - VAL_LO + 1;
  // Boundary-scan instruction that selects the fault register.
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] FAULT_INJECT_INSTRUCTION = 10'h015;
  // Error message width carried through for monitoring.
  localparam int ERR_MSG_W = 46;
  // Injection only characterised at this detection clock rate.
  localparam int DETECT_MHZ = 50;
  // Least number of low flag cycles between two reports.
  localparam int FLAG_LOW_CYCLES = 32;
  localparam logic [4:0] HOLD_LAST = 5'(FLAG_LOW_CYCLES - 1);

  typedef enum logic [1:0] {
    CFI_NONE = 2'h0,
    CFI_SINGLE = 2'h1,
    CFI_DADJ = 2'h2,
    CFI_BAD = 2'h3
  } cfi_kind_t;

  typedef enum logic [2:0] {
    FLAG_IDLE = 3'h1,
    FLAG_HIGH = 3'h2,
    FLAG_HOLD = 3'h4
  } cfi_flag_state_t;

  function automatic cfi_kind_t kindOf(input logic [FI_W-1:0] word);
    kindOf = cfi_kind_t'(word[TYPE_HI:TYPE_LO]);
  endfunction : kindOf

  function automatic logic [LOC_W-1:0] locOf(input logic [FI_W-1:0] word);
    locOf = word[LOC_HI:LOC_LO];
  endfunction : locOf

  function automatic logic [VAL_W-1:0] valOf(input logic [FI_W-1:0] word);
    valOf = word[VAL_HI:VAL_LO];
  endfunction : valOf

  // Bits to invert in the byte at addr; the invalid code decodes as none.
  function automatic logic [VAL_W-1:0] flipMask(input logic [FI_W-1:0] word,
                                                input logic [LOC_W-1:0] addr);
    logic [LOC_W-1:0] next;
    next = LOC_W'(locOf(word) + 11'h001);
    flipMask = 8'h00;
    if (kindOf(word) == CFI_SINGLE && addr == locOf(word)) begin
      flipMask = valOf(word);
    end else if (kindOf(word) == CFI_DADJ && (addr == locOf(word) || addr == next)) begin
      flipMask = valOf(word);
    end
  endfunction : flipMask
endpackage : cfi_pkg

// ### hdl/cfi_error_flag.sv
/*
  Error flag pin driver: one-cycle report pulses with an enforced low gap.
  Assumes report comes from the detection engine on the same clock.
*/
module cfi_error_flag (
  input wire logic clk,
  input wire logic rst,
  input wire logic edEnable,
  input wire logic openDrain,
  input wire logic report,
  input wire logic gpioOut,
  input wire logic gpioOe,
  output logic pinOut,
  output logic pinOe,
  output logic coreError
);
  cfi_pkg::cfi_flag_state_t state;
  cfi_pkg::cfi_flag_state_t next_state;
  logic [4:0] holdCnt;
  logic pending;
  logic take;
  logic want;
  logic flagNext;
  logic [5:0] lowCnt;

  assign want = edEnable && (report || pending);

  always_comb begin
    next_state = state;
    unique case (state)
      cfi_pkg::FLAG_IDLE: if (want) next_state = cfi_pkg::FLAG_HIGH;
      cfi_pkg::FLAG_HIGH: next_state = cfi_pkg::FLAG_HOLD;
      cfi_pkg::FLAG_HOLD: begin
        if (holdCnt == cfi_pkg::HOLD_LAST) begin
          next_state = want ? cfi_pkg::FLAG_HIGH : cfi_pkg::FLAG_IDLE;
        end
      end
      default: next_state = cfi_pkg::FLAG_IDLE;
    endcase
  end

  assign take = next_state == cfi_pkg::FLAG_HIGH;
  assign flagNext = take;

  always_ff @(posedge clk) begin
    if (rst) state <= cfi_pkg::FLAG_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge clk) begin
    if (rst || state != cfi_pkg::FLAG_HOLD) holdCnt <= 5'h00;
    else holdCnt <= holdCnt + 5'h01;
  end

  // A report that cannot be shown now waits; a new one beats the clear.
  always_ff @(posedge clk) begin
    if (rst || !edEnable) pending <= 1'b0;
    else pending <= (pending && !take) || (report && (pending || !take));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      coreError <= 1'b0;
    end else begin
      coreError <= flagNext;
      if (!edEnable) begin
        pinOut <= gpioOut;
        pinOe <= gpioOe;
      end else if (openDrain) begin
        pinOut <= 1'b0;
        pinOe <= !flagNext;
      end else begin
        pinOut <= flagNext;
        pinOe <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) lowCnt <= 6'h3f;
    else if (coreError) lowCnt <= 6'h00;
    else if (lowCnt != 6'h3f) lowCnt <= lowCnt + 6'h01;
  end

  property p_low_hold;
    @(posedge clk) disable iff (rst) $rose(coreError) |-> lowCnt >= 6'h20;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("flag low gap too short");

  property p_report_shown;
    @(posedge clk) disable iff (rst)
      edEnable && report && state == cfi_pkg::FLAG_IDLE |=> coreError ##1 !coreError;
  endproperty
  a_report_shown: assert property (p_report_shown) else $error("report not flagged");

  property p_push_pull;
    @(posedge clk) disable iff (rst)
      edEnable && !openDrain ##1 1'b1 |-> pinOe && pinOut == coreError;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin wrong");

  property p_open_drain;
    @(posedge clk) disable iff (rst)
      edEnable && openDrain ##1 1'b1 |-> !pinOut && pinOe == !coreError;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin wrong");

  property p_gpio;
    @(posedge clk) disable iff (rst)
      !edEnable |=> pinOut == $past(gpioOut) && pinOe == $past(gpioOe) && !coreError;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not released to user");
endmodule : cfi_error_flag

// ### hdl/cfi_fault_inject.sv
/*
  Fault injection path for configuration readback plus the error flag.
  Assumes a TAP controller on tck supplies the decoded instruction and
  shift/update strobes, and the detection engine supplies frame windows.
*/
// What this block does
// - Single, double, double-adjacent corruption patterns.
// - Requested injection inverts readback, enters test mode.
// - No transfer during last and first frame.
// - Injection applies to first frame only.
// - Error information readable at any time.
// - Type bits 20:19, location 18:8, value 7:0.
// - Value marks corrupted bits in addressed byte.
// - Code 10 double-adjacent, code 00 none.
// - Code 11 invalid, no injection.
// - Flag goes high on detected corruption.
// - Detection disabled leaves pin as user I/O.
// - Pin defaults to push-pull output.
// - Pin optionally open-drain.
// - Core error output carries the flag in every pin mode, not the pin level.
// - Injection runs in-system, no reconfiguration.
// - 21-bit scan register, 10-bit instruction.
// - Flag low 32 cycles between reports.
module cfi_fault_inject (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tapReset,
  input wire logic [cfi_pkg::IR_W-1:0] irCode,
  input wire logic shiftDr,
  input wire logic updateDr,
  input wire logic tdi,
  output logic tdo,
  input wire logic edEnable,
  input wire logic openDrain,
  input wire logic lastFrame,
  input wire logic firstFrame,
  input wire logic rbValid,
  input wire logic [cfi_pkg::LOC_W-1:0] rbAddr,
  input wire logic [cfi_pkg::VAL_W-1:0] rbData,
  output logic rbOutValid,
  output logic [cfi_pkg::VAL_W-1:0] rbOutData,
  output logic errorTestMode,
  input wire logic [cfi_pkg::ERR_MSG_W-1:0] errMsg,
  output logic [cfi_pkg::ERR_MSG_W-1:0] errInfo,
  input wire logic frameError,
  input wire logic gpioOut,
  input wire logic gpioOe,
  output logic errPinOut,
  output logic errPinOe,
  output logic coreError
);
  // Link side, clocked by tck.
  logic selected;
  logic [cfi_pkg::FI_W-1:0] scanReg;
  logic [cfi_pkg::FI_W-1:0] heldWord;
  logic updToggle;

  // Detection side, clocked by clk.
  logic togMeta;
  logic togSync;
  logic togSeen;
  logic newWord;
  logic window;
  logic pendValid;
  logic [cfi_pkg::FI_W-1:0] pendWord;
  logic [cfi_pkg::FI_W-1:0] injWord;
  logic injActive;
  logic [cfi_pkg::VAL_W-1:0] mask;

  assign selected = irCode == cfi_pkg::FAULT_INJECT_INSTRUCTION;

  always_ff @(posedge tck) begin
    if (tapReset) begin
      scanReg <= cfi_pkg::FI_RESET;
    end else if (selected && shiftDr) begin
      scanReg <= {tdi, scanReg[cfi_pkg::FI_W-1:1]};
    end
  end

  assign tdo = scanReg[0];

  // The held word stays put until the next update, which is what lets
  // the detection side copy it after the toggle is seen. A second update
  // issued within a few clk cycles of the first may be missed.
  always_ff @(posedge tck) begin
    if (tapReset) begin
      heldWord <= cfi_pkg::FI_RESET;
      updToggle <= 1'b0;
    end else if (selected && updateDr) begin
      heldWord <= scanReg;
      updToggle <= !updToggle;
    end
  end

  // The chain and its edge memory run through reset, so a toggle left
  // odd by earlier loads is not taken for a fresh word after reset.
  always_ff @(posedge clk) begin
    togMeta <= updToggle;
    togSync <= togMeta;
  end

  always_ff @(posedge clk) begin
    togSeen <= togSync;
  end

  assign newWord = togSync ^ togSeen;
  assign window = lastFrame || firstFrame;

  always_ff @(posedge clk) begin
    if (rst) pendWord <= cfi_pkg::FI_RESET;
    else if (newWord) pendWord <= heldWord;
  end

  // A word arriving in the transfer cycle stays pending.
  always_ff @(posedge clk) begin
    if (rst) pendValid <= 1'b0;
    else pendValid <= newWord || (pendValid && window);
  end

  // Transfer happens in user mode without any reconfiguration.
  always_ff @(posedge clk) begin
    if (rst) begin
      injWord <= cfi_pkg::FI_RESET;
    end else if (pendValid && !window) begin
      injWord <= pendWord;
    end
  end

  always_comb begin
    unique case (cfi_pkg::kindOf(injWord))
      cfi_pkg::CFI_SINGLE: injActive = 1'b1;
      cfi_pkg::CFI_DADJ: injActive = 1'b1;
      cfi_pkg::CFI_NONE: injActive = 1'b0;
      cfi_pkg::CFI_BAD: injActive = 1'b0;
    endcase
  end

  // Double-bit errors come from a value with two bits set.
  always_comb begin
    mask = 8'h00;
    if (edEnable && firstFrame && rbValid) begin
      mask = cfi_pkg::flipMask(injWord, rbAddr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rbOutValid <= 1'b0;
      rbOutData <= 8'h00;
    end else begin
      rbOutValid <= rbValid;
      rbOutData <= rbData ^ mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) errorTestMode <= 1'b0;
    else errorTestMode <= edEnable && injActive;
  end

  // Monitoring copy runs every cycle whatever the injection does.
  always_ff @(posedge clk) begin
    if (rst) errInfo <= '0;
    else errInfo <= errMsg;
  end

  cfi_error_flag u_flag (
    .clk(clk),
    .rst(rst),
    .edEnable(edEnable),
    .openDrain(openDrain),
    .report(frameError),
    .gpioOut(gpioOut),
    .gpioOe(gpioOe),
    .pinOut(errPinOut),
    .pinOe(errPinOe),
    .coreError(coreError)
  );

  property p_hold_window;
    @(posedge clk) disable iff (rst) window |=> $stable(injWord);
  endproperty
  a_hold_window: assert property (p_hold_window) else $error("word moved in window");

  property p_transfer;
    @(posedge clk) disable iff (rst)
      pendValid && !window |=> injWord == $past(pendWord);
  endproperty
  a_transfer: assert property (p_transfer) else $error("pending word not loaded");

  property p_first_only;
    @(posedge clk) disable iff (rst) !firstFrame |=> rbOutData == $past(rbData);
  endproperty
  a_first_only: assert property (p_first_only) else $error("flip outside first frame");

  property p_invalid;
    @(posedge clk) disable iff (rst)
      cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_BAD |=> rbOutData == $past(rbData)
        && !errorTestMode;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code injected");

  property p_disabled;
    @(posedge clk) disable iff (rst)
      !edEnable |=> rbOutData == $past(rbData) && !errorTestMode;
  endproperty
  a_disabled: assert property (p_disabled) else $error("injection while disabled");

  property p_single;
    @(posedge clk) disable iff (rst)
      edEnable && firstFrame && rbValid && cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_SINGLE
        && rbAddr == cfi_pkg::locOf(injWord)
        |=> rbOutData == ($past(rbData) ^ $past(cfi_pkg::valOf(injWord))) && errorTestMode;
  endproperty
  a_single: assert property (p_single) else $error("single byte not flipped");

  property p_adjacent;
    @(posedge clk) disable iff (rst)
      edEnable && firstFrame && rbValid && cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_DADJ
        && rbAddr == cfi_pkg::LOC_W'(cfi_pkg::locOf(injWord) + 11'h001)
        |=> rbOutData == ($past(rbData) ^ $past(cfi_pkg::valOf(injWord)));
  endproperty
  a_adjacent: assert property (p_adjacent) else $error("second byte not flipped");

  property p_info;
    @(posedge clk) disable iff (rst) 1'b1 |=> errInfo == $past(errMsg);
  endproperty
  a_info: assert property (p_info) else $error("error info not passed");

  property p_tdo;
    @(posedge tck) disable iff (tapReset)
      selected && shiftDr |=> tdo == $past(scanReg[1]);
  endproperty
  a_tdo: assert property (p_tdo) else $error("scan register not shifting");

  property p_new_pending;
    @(posedge clk) disable iff (rst)
      newWord |=> pendValid && pendWord == $past(heldWord);
  endproperty
  a_new_pending: assert property (p_new_pending) else $error("word not captured");

  property p_window_pending;
    @(posedge clk) disable iff (rst)
      pendValid && window |=> pendValid;
  endproperty
  a_window_pending: assert property (p_window_pending) else $error("pending word lost");

  property p_test_mode;
    @(posedge clk) disable iff (rst)
      edEnable && (cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_SINGLE
        || cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_DADJ) |=> errorTestMode;
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("test mode not entered");

  property p_none;
    @(posedge clk) disable iff (rst)
      cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_NONE
        |=> rbOutData == $past(rbData) && !errorTestMode;
  endproperty
  a_none: assert property (p_none) else $error("injection without type");

  property p_valid_pass;
    @(posedge clk) disable iff (rst)
      1'b1 |=> rbOutValid == $past(rbValid);
  endproperty
  a_valid_pass: assert property (p_valid_pass) else $error("readback valid lost");

  property p_idle_byte;
    @(posedge clk) disable iff (rst)
      !rbValid |=> rbOutData == $past(rbData);
  endproperty
  a_idle_byte: assert property (p_idle_byte) else $error("idle byte altered");

  property p_value_bits;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((rbOutData ^ $past(rbData)) & ~$past(cfi_pkg::valOf(injWord))) == 8'h00;
  endproperty
  a_value_bits: assert property (p_value_bits) else $error("unmarked bit flipped");

  property p_adjacent_first;
    @(posedge clk) disable iff (rst)
      edEnable && firstFrame && rbValid && cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_DADJ
        && rbAddr == cfi_pkg::locOf(injWord)
        |=> rbOutData == ($past(rbData) ^ $past(cfi_pkg::valOf(injWord))) && errorTestMode;
  endproperty
  a_adjacent_first: assert property (p_adjacent_first) else $error("first byte not flipped");

  property p_single_other;
    @(posedge clk) disable iff (rst)
      edEnable && rbValid && cfi_pkg::kindOf(injWord) == cfi_pkg::CFI_SINGLE
        && rbAddr != cfi_pkg::locOf(injWord) |=> rbOutData == $past(rbData);
  endproperty
  a_single_other: assert property (p_single_other) else $error("wrong byte flipped");

  property p_shift_in;
    @(posedge tck) disable iff (tapReset)
      selected && shiftDr |=> scanReg[cfi_pkg::FI_W-1] == $past(tdi);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not entered");

  property p_update;
    @(posedge tck) disable iff (tapReset)
      selected && updateDr |=> heldWord == $past(scanReg) && updToggle != $past(updToggle);
  endproperty
  a_update: assert property (p_update) else $error("update not latched");

  property p_shift_hold;
    @(posedge tck) disable iff (tapReset)
      !shiftDr |=> $stable(scanReg);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("scan register moved");
endmodule : cfi_fault_inject

// ### tb/cfi_jtag_host.sv
/*
  Test host model that loads the fault word through the scan side.
  Assumes the bench calls its tasks; tck runs only inside a load or a clear.
*/
module cfi_jtag_host (
  output logic tck,
  output logic tapReset,
  output logic [cfi_pkg::IR_W-1:0] irCode,
  output logic shiftDr,
  output logic updateDr,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tapReset = 1'b0;
    irCode = 10'h000;
    shiftDr = 1'b0;
    updateDr = 1'b0;
    tdi = 1'b0;
  end
  task automatic pulse();
    #16 tck = 1'b1;
    #16 tck = 1'b0;
  endtask : pulse
  task automatic clearTap();
    tapReset = 1'b1;
    pulse();
    tapReset = 1'b0;
  endtask : clearTap
  // Callers load with the bench clk at 100 MHz, in user mode.
  task automatic load(input logic [cfi_pkg::FI_W-1:0] word);
    irCode = cfi_pkg::FAULT_INJECT_INSTRUCTION;
    shiftDr = 1'b1;
    for (int k = 0; k < cfi_pkg::FI_W; k++) begin
      tdi = word[k];
      pulse();
    end
    shiftDr = 1'b0;
    updateDr = 1'b1;
    pulse();
    updateDr = 1'b0;
    // A released data line flips so a stale bit never looks valid.
    tdi = ~tdi;
    irCode = 10'h000;
  endtask : load
endmodule : cfi_jtag_host

// ### tb/cfi_fault_inject_tb.sv
/*
  Self-checking bench for the fault injection path and error flag.
  Assumes the host model drives the scan side on its own stopped clock.
*/
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module cfi_fault_inject_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] kind;
    logic [10:0] loc;
    logic [7:0] val;
    logic [10:0] addr;
    logic ff;
    logic [7:0] data;
    logic [7:0] exp;
  } cfi_row_t;
  cfi_row_t rows [8] = '{
    '{2'h1, 11'h005, 8'h01, 11'h005, 1'b1, 8'ha5, 8'ha4},
    '{2'h1, 11'h005, 8'h01, 11'h006, 1'b1, 8'ha5, 8'ha5},
    '{2'h1, 11'h005, 8'h03, 11'h005, 1'b1, 8'ha5, 8'ha6},
    '{2'h2, 11'h7ff, 8'h81, 11'h7ff, 1'b1, 8'h00, 8'h81},
    '{2'h2, 11'h7ff, 8'h81, 11'h000, 1'b1, 8'h0f, 8'h8e},
    '{2'h2, 11'h010, 8'h81, 11'h010, 1'b0, 8'h0f, 8'h0f},
    '{2'h3, 11'h005, 8'hff, 11'h005, 1'b1, 8'h5a, 8'h5a},
    '{2'h0, 11'h005, 8'hff, 11'h005, 1'b1, 8'h5a, 8'h5a}};
  logic clk, rst, tck, tapReset, shiftDr, updateDr, tdi, tdo, edEnable, openDrain;
  logic lastFrame, firstFrame, rbValid, rbOutValid, errorTestMode, frameError;
  logic gpioOut, gpioOe, errPinOut, errPinOe, coreError;
  logic [9:0] irCode;
  logic [10:0] rbAddr;
  logic [7:0] rbData, rbOutData;
  logic [45:0] errMsg, errInfo;
  int failures = 0;
  int compares = 0;
  int n;
  cfi_jtag_host u_host (.tck, .tapReset, .irCode, .shiftDr, .updateDr, .tdi);
  cfi_fault_inject u_cfi_fault_inject (.clk, .rst, .tck, .tapReset, .irCode,
    .shiftDr, .updateDr, .tdi, .tdo, .edEnable, .openDrain, .lastFrame,
    .firstFrame, .rbValid, .rbAddr, .rbData, .rbOutValid, .rbOutData,
    .errorTestMode, .errMsg, .errInfo, .frameError, .gpioOut, .gpioOe,
    .errPinOut, .errPinOe, .coreError);
  always #5 clk = ~clk;
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic rb(input logic [10:0] a, input logic [7:0] d, input logic f);
    @(posedge clk);
    rbValid <= 1'b1;
    rbAddr <= a;
    rbData <= d;
    firstFrame <= f;
    @(posedge clk);
    rbValid <= 1'b0;
    firstFrame <= 1'b0;
    @(negedge clk);
  endtask : rb
  // Counts low cycles until the flag rises; a missing rise ends the run.
  task automatic waitFlag(output int lows);
    lows = 0;
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      if (coreError === 1'b1) begin
        return;
      end
      lows++;
    end
    failures++;
    end_of_test();
  endtask : waitFlag
  initial begin
    {clk, edEnable, rst} = 3'h7;
    {openDrain, lastFrame, firstFrame, rbValid, frameError, gpioOut, gpioOe} = 7'h00;
    rbAddr = 11'h000;
    rbData = 8'h00;
    errMsg = 46'h1;
    // The host sets its idle levels at time zero; clear the scan side after that.
    @(posedge clk);
    u_host.clearTap();
    repeat (16) @(posedge clk);
    @(negedge clk);
    `CHK("resetOut", 5'h00, {coreError, errPinOe, errorTestMode, rbOutValid, |errInfo})
    `CHK("tdoReset", 1'b0, tdo)
    @(posedge clk) rst <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      u_host.load({rows[i].kind, rows[i].loc, rows[i].val});
      `CHK("tdo", rows[i].val[0], tdo)
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK("testMode", rows[i].kind inside {2'h1, 2'h2}, errorTestMode)
      rb(rows[i].addr, rows[i].data, rows[i].ff);
      `CHK("rbOutData", rows[i].exp, rbOutData)
      `CHK("rbOutValid", 1'b1, rbOutValid)
    end
    $display("test rows done");
    @(posedge clk) lastFrame <= 1'b1;
    u_host.load({2'h1, 11'h005, 8'h01});
    repeat (10) @(posedge clk);
    @(negedge clk);
    `CHK("heldMode", 1'b0, errorTestMode)
    @(posedge clk) lastFrame <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("loadMode", 1'b1, errorTestMode)
    $display("test window done");
    // Raise the flag, check the push-pull pin, then check the low gap before the next.
    @(posedge clk) frameError <= 1'b1;
    @(posedge clk) frameError <= 1'b0;
    waitFlag(n);
    `CHK("pushPull", 2'h3, {errPinOut, errPinOe})
    @(posedge clk) frameError <= 1'b1;
    @(posedge clk) frameError <= 1'b0;
    waitFlag(n);
    `CHK("lowGap", cfi_pkg::FLAG_LOW_CYCLES, n + 1)
    $display("test flag done");
    repeat (40) @(posedge clk);
    openDrain <= 1'b1;
    frameError <= 1'b1;
    @(posedge clk) frameError <= 1'b0;
    waitFlag(n);
    `CHK("odHigh", 2'h0, {errPinOut, errPinOe})
    @(negedge clk);
    `CHK("odLow", 2'h1, {errPinOut, errPinOe})
    $display("test open drain done");
    repeat (40) @(posedge clk);
    {openDrain, edEnable, gpioOut, gpioOe, frameError} <= 5'h07;
    errMsg <= 46'h2aaa_aaaa_aaaa;
    @(posedge clk) frameError <= 1'b0;
    errMsg <= 46'h1555_5555_5555;
    @(negedge clk);
    `CHK("errInfo", 46'h2aaa_aaaa_aaaa, errInfo)
    `CHK("userPin", 3'h6, {errPinOut, errPinOe, coreError})
    rb(11'h005, 8'ha5, 1'b1);
    `CHK("offData", 8'ha5, rbOutData)
    `CHK("offMode", 1'b0, errorTestMode)
    $display("test disabled done");
    @(posedge clk) edEnable <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("preReset", 1'b1, errorTestMode)
    // A reset stands in for the reconfiguration after testing.
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("cleared", 3'h1, {errorTestMode, errPinOut, errPinOe})
    $display("test final reset done");
    end_of_test();
  end
endmodule : cfi_fault_inject_tb
